// *** tsc_regs.svh ***
// Constants for the touch converter serial control block
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// ----------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------
`define TSC_CMD_FIELD_BITS 7
`define TSC_CMD_LAST_IDX 3'h5
`define TSC_CHAN_MSB 6
`define TSC_CHAN_LSB 4
`define TSC_RES_POS 3
`define TSC_REF_POS 2
`define TSC_PWR_MSB 1
`define TSC_PWR_LSB 0

// ----------------------------------------------------------------
// Channel and power codes
// ----------------------------------------------------------------
`define TSC_CHAN_XPLUS 3'h1
`define TSC_CHAN_YPLUS 3'h5
`define TSC_CHAN_AUX_A 3'h2
`define TSC_CHAN_AUX_B 3'h6
`define TSC_PWR_DOWN_IRQ 2'h0
`define TSC_PWR_ALWAYS_ON 2'h3

// ----------------------------------------------------------------
// Result lengths and reset values
// ----------------------------------------------------------------
`define TSC_RES12_BITS 4'hc
`define TSC_RES8_BITS 4'h8
`define TSC_RST_CHAN 3'h0
`define TSC_RST_PWR 2'h0
`define TSC_TCSR_NS 0

`endif

// *** tsc_pkg.sv ***
// Types for the touch converter serial control block
package tsc_pkg;

  // ----------------------------------------------------------------
  // Command receiver states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    TSC_HUNT,
    TSC_CMD
  } tsc_rx_t;

  // ----------------------------------------------------------------
  // Edge detector state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sck_q;
    logic rise;
    logic fall;
    logic din;
  } tsc_edge_st_t;

  // ----------------------------------------------------------------
  // Main control state
  // ----------------------------------------------------------------
  typedef struct packed {
    tsc_rx_t rx;
    logic [2:0] cnt;
    logic [5:0] cmd_sh;
    logic [2:0] chan;
    logic res8;
    logic ref_sel;
    logic [1:0] pwr;
    logic x_drv;
    logic y_drv;
    logic ext_ref;
    logic conv_start;
    logic busy_pend;
    logic busy;
    logic [3:0] bits_left;
    logic [11:0] res_sh;
    logic dout;
    logic oe;
    logic irq_n;
    logic irq_oe;
  } tsc_st_t;

endpackage

// *** tsc_edge_if.sv ***
// Serial clock edge events passed from the detector to the control logic
`timescale 1ns/1ps
interface tsc_edge_if;
  logic rise;
  logic fall;
  logic din;
  modport src (output rise, output fall, output din);
  modport snk (input rise, input fall, input din);
endinterface

// *** tsc_edge_det.sv ***
// Serial clock edge detector with chip select gating
`timescale 1ns/1ps
module tsc_edge_det
  import tsc_pkg::*;
(
  input wire logic clk_i,         // System clock
  input wire logic rst_n_i,       // Async reset, active low
  input wire logic serial_clock_i, // Host serial clock level
  input wire logic cs_n_i,        // Chip select, active low
  input wire logic din_i,         // Serial data in
  tsc_edge_if.src ev              // Edge events out
);

  tsc_edge_st_t st;
  tsc_edge_st_t next_st;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // deselect gating, immediate
  // Edges while deselected are dropped at once, no delay
  always_comb begin
    next_st = st;
    next_st.sck_q = serial_clock_i;
    next_st.rise = serial_clock_i & ~st.sck_q & ~cs_n_i;
    next_st.fall = ~serial_clock_i & st.sck_q & ~cs_n_i;
    // Data taken with the rising edge, matching its own cycle
    next_st.din = din_i;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ev.rise = st.rise;
  assign ev.fall = st.fall;
  assign ev.din = st.din;

endmodule

// *** tsc_serial_ctl.sv ***
// Serial command and result sequencing for a touch screen converter
// Contract
// - Chip select falling begins an operation; device then watches serial input.
// - Input bits are discarded until the first one, which is the start bit.
// - Command byte is eight clocks MSB first: start, channel, mode, power.
// - Channel 001 X-plus Y drive; 101 Y-plus X drive; 010, 110 aux.
// - Resolution bit zero gives 12-bit result, one gives 8-bit result.
// - Reference bit one uses external; zero uses supply for panel channels.
// - Power 11 stays powered; 00 powers down and enables touch interrupt.
// - Standard framing is three bytes, 24 serial clocks per conversion.
// - Next command accepted during result shifting, giving 16-clock framing.
// - Fifteen-clock framing is supported for hosts with odd-length transfers.
// - Serial input sampled on the rising serial clock edge.
// - Output data and busy change only on falling serial clock edges.
// - Serial clock edges ignored immediately once chip select is high.
// - Output and busy driven only while selected.
// - Output and busy are released one system clock after chip select goes high.
// - Enabled interrupt pulls touch interrupt low while panel is touched.
`timescale 1ns/1ps
`include "tsc_regs.svh"
module tsc_serial_ctl
  import tsc_pkg::*;
(
  input wire logic clk_i,            // System clock, 250 MHz
  input wire logic rst_n_i,          // Async reset, active low
  input wire logic cs_n_i,           // Chip select, active low
  input wire logic serial_clock_i,   // Host serial clock
  input wire logic din_i,            // Serial data in
  input wire logic [11:0] conv_result_i, // Converter result word
  input wire logic touch_detect_i,   // Panel touched level
  input wire logic touch_irq_n_i,    // Interrupt wire level
  output logic dout_o,               // Serial data out
  output logic dout_oe_o,            // Data out enable
  output logic busy_o,               // Busy out
  output logic busy_oe_o,            // Busy enable
  output logic touch_irq_n_o,        // Interrupt drive value
  output logic touch_irq_oe_o,       // Interrupt pull enable
  output logic [2:0] channel_sel_o,  // Selected input channel
  output logic resolution_sel_o,     // High for 8-bit mode
  output logic reference_sel_o,      // High for external reference
  output logic [1:0] power_ctl_o,    // Power control code
  output logic x_drive_o,            // X panel drivers on
  output logic y_drive_o,            // Y panel drivers on
  output logic ext_ref_o,            // Converter uses external reference
  output logic stay_powered_o,       // Keep converter powered
  output logic conv_start_o          // One-cycle conversion start
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Panel drivers for a channel code
  function automatic logic [1:0] drv_of(input logic [2:0] ch);
    logic [1:0] d;
    d = 2'h0;
    // channel driver decode
    // Bit 1 is the Y drivers, bit 0 the X drivers
    case (ch)
      `TSC_CHAN_XPLUS: d = 2'h2;
      `TSC_CHAN_YPLUS: d = 2'h1;
      default: d = 2'h0;
    endcase
    return d;
  endfunction

  // Aux channels always need the external reference
  function automatic logic is_aux(input logic [2:0] ch);
    return (ch == `TSC_CHAN_AUX_A) || (ch == `TSC_CHAN_AUX_B);
  endfunction

  tsc_edge_if ev ();
  tsc_st_t st;
  tsc_st_t next_st;
  logic [6:0] fields;

  tsc_edge_det u_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .serial_clock_i(serial_clock_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .ev(ev)
  );

  // Full field set once the last command bit arrives
  assign fields = {st.cmd_sh, ev.din};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.conv_start = 1'b0;
    next_st.oe = ~cs_n_i;
    // pull interrupt low when enabled and touched
    next_st.irq_oe = (st.pwr == `TSC_PWR_DOWN_IRQ) & touch_detect_i;
    next_st.irq_n = 1'b0;
    if (cs_n_i) begin
      // deselect ends the frame, next select restarts hunting
      next_st.rx = TSC_HUNT;
      next_st.cnt = 3'h0;
      next_st.busy_pend = 1'b0;
      next_st.busy = 1'b0;
      next_st.bits_left = 4'h0;
      next_st.dout = 1'b0;
    end else begin
      // command bits taken on rising edges
      if (ev.rise) begin
        case (st.rx)
          TSC_HUNT: begin
            // zeros before the start bit are dropped
            if (ev.din) begin
              next_st.rx = TSC_CMD;
              next_st.cnt = 3'h0;
            end
          end
          TSC_CMD: begin
            next_st.cmd_sh = {st.cmd_sh[4:0], ev.din};
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == `TSC_CMD_LAST_IDX + 3'h1) begin
              next_st.rx = TSC_HUNT;
              next_st.chan = fields[6:4];
              next_st.res8 = fields[3];
              next_st.ref_sel = fields[2];
              next_st.pwr = fields[1:0];
              {next_st.y_drv, next_st.x_drv} = drv_of(fields[6:4]);
              // supply reference only for non-aux channels
              next_st.ext_ref = fields[2] | is_aux(fields[6:4]);
              next_st.conv_start = 1'b1;
              // restarts any shift still in progress
              next_st.busy_pend = 1'b1;
            end
          end
          default: next_st.rx = TSC_HUNT;
        endcase
      end
      // outputs move only on falling edges
      if (ev.fall) begin
        next_st.busy = 1'b0;
        if (st.busy_pend) begin
          // one clock of busy, result loaded
          next_st.busy_pend = 1'b0;
          next_st.busy = 1'b1;
          next_st.dout = 1'b0;
          next_st.res_sh = conv_result_i;
          next_st.bits_left = st.res8 ? `TSC_RES8_BITS : `TSC_RES12_BITS;
        end else if (st.bits_left != 4'h0) begin
          // MSB first, one bit per fall
          next_st.dout = st.res_sh[11];
          next_st.res_sh = {st.res_sh[10:0], 1'b0};
          next_st.bits_left = st.bits_left - 4'h1;
        end else begin
          next_st.dout = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.rx <= TSC_HUNT;
      st.chan <= `TSC_RST_CHAN;
      st.pwr <= `TSC_RST_PWR;
      st.irq_n <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from state
  // ----------------------------------------------------------------
  assign dout_o = st.dout;
  assign dout_oe_o = st.oe;
  assign busy_o = st.busy;
  assign busy_oe_o = st.oe;
  assign touch_irq_n_o = st.irq_n;
  assign touch_irq_oe_o = st.irq_oe;
  assign channel_sel_o = st.chan;
  assign resolution_sel_o = st.res8;
  assign reference_sel_o = st.ref_sel;
  assign power_ctl_o = st.pwr;
  assign x_drive_o = st.x_drv;
  assign y_drive_o = st.y_drv;
  assign ext_ref_o = st.ext_ref;
  // powered between conversions only for code 11
  assign stay_powered_o = (st.pwr == `TSC_PWR_ALWAYS_ON);
  assign conv_start_o = st.conv_start;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sel_drive_a: assert property (!cs_n_i |=> dout_oe_o && busy_oe_o)
    else $error("outputs not driven while selected");
  desel_float_a: assert property (cs_n_i |=> !dout_oe_o && !busy_oe_o)
    else $error("outputs driven while deselected");
  start_hunt_a: assert property (
    (st.rx == TSC_HUNT) && ev.rise && !ev.din && !cs_n_i |=> st.rx == TSC_HUNT)
    else $error("zero bit taken as start");
  cmd_fields_a: assert property (
    conv_start_o |-> {channel_sel_o, resolution_sel_o, reference_sel_o, power_ctl_o} ==
    $past(fields))
    else $error("command fields misplaced");
  rise_sample_a: assert property (conv_start_o |-> $past(ev.rise) && !$past(cs_n_i))
    else $error("command finished without rising edge");
  busy_fall_a: assert property ($rose(busy_o) |-> $past(ev.fall))
    else $error("busy rose without falling edge");
  dout_fall_a: assert property ($changed(dout_o) |-> $past(ev.fall) || $past(cs_n_i))
    else $error("data changed off a falling edge");
  desel_ignore_a: assert property (cs_n_i |=> !conv_start_o && !busy_o)
    else $error("edge acted on while deselected");
  // Expected drivers spelled out from the channel table, not from the decode function
  chan_drive_a: assert property (
    conv_start_o |-> {y_drive_o, x_drive_o} ==
    ((channel_sel_o == `TSC_CHAN_XPLUS) ? 2'h2 :
    (channel_sel_o == `TSC_CHAN_YPLUS) ? 2'h1 : 2'h0))
    else $error("panel drivers wrong for channel");
  rsvd_off_a: assert property (
    conv_start_o && (channel_sel_o != `TSC_CHAN_XPLUS) && (channel_sel_o != `TSC_CHAN_YPLUS)
    |-> !x_drive_o && !y_drive_o)
    else $error("reserved channel drives panel");
  ref_sel_a: assert property (
    conv_start_o |-> ext_ref_o == (reference_sel_o ||
    (channel_sel_o == `TSC_CHAN_AUX_A) || (channel_sel_o == `TSC_CHAN_AUX_B)))
    else $error("reference choice wrong");
  res_len_a: assert property (
    $rose(busy_o) |-> st.bits_left == (resolution_sel_o ? 4'h8 : 4'hc))
    else $error("result length wrong");
  busy_one_a: assert property (busy_o && ev.fall && !st.busy_pend |=> !busy_o)
    else $error("busy held past one clock");
  irq_gate_a: assert property (
    touch_irq_oe_o |-> $past(power_ctl_o) == 2'h0 && $past(touch_detect_i))
    else $error("interrupt pulled while disabled");
  // Skip the first edge after reset, the pull register was still held clear
  irq_pull_a: assert property (
    $past(rst_n_i) && $past(power_ctl_o) == 2'h0 && $past(touch_detect_i)
    |-> touch_irq_oe_o && !touch_irq_n_o)
    else $error("touch not signalled");

  busy_seen_c: cover property ($rose(busy_o) ##[1:200] $fell(busy_o));
  overlap_c: cover property (st.bits_left != 4'h0 && conv_start_o);
  aux_chan_c: cover property (conv_start_o && is_aux(channel_sel_o));
  res8_c: cover property ($rose(busy_o) && resolution_sel_o);

endmodule

// *** tsc_host_model.sv ***
// Host serial port model driving the converter command link
`timescale 1ns/1ps
module tsc_host_model (
  input wire logic clk_i,     // System clock
  input wire logic dout_i,    // Device data out
  input wire logic dout_oe_i, // Device data enable
  input wire logic busy_i,    // Device busy
  input wire logic busy_oe_i, // Device busy enable
  output logic cs_n_o,        // Chip select, active low
  output logic sclk_o,        // Serial clock
  output logic din_o          // Serial data to device
);
  logic cap_d [1:64];
  logic cap_b [1:64];
  logic bad;
  // Deselected, clock parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    bad = 1'b0;
  end
  // One frame of n clocks, din per clock from dv
  task automatic run(input logic [0:63] dv, input int n);
    cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int k = 1; k <= n; k++) begin
      din_o = dv[k-1];
      repeat (4) @(negedge clk_i);
      cap_d[k] = dout_i;
      cap_b[k] = busy_i;
      if (dout_oe_i !== 1'b1 || busy_oe_i !== 1'b1) bad = 1'b1;
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      // Outputs may only move after a fall
      if (dout_i !== cap_d[k] || busy_i !== cap_b[k]) bad = 1'b1;
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    din_o = ~din_o;
    // Enables drop one clock after deselect
    repeat (2) @(negedge clk_i);
  endtask
  // Clock left running while deselected, din held high
  task automatic idle_clk(input int n);
    din_o = 1'b1;
    repeat (n) begin
      repeat (2) @(negedge clk_i);
      sclk_o = ~sclk_o;
    end
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the touch converter serial control block
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] cmd;
    logic [11:0] res;
    logic [2:0] xye;
  } tsc_row_t;
  logic clk_i, rst_n_i, touch, cs_n, sclk, din, irq_wire;
  logic dout, dout_oe, busy, busy_oe, irq_n, irq_oe;
  logic res_sel, ref_sel, x_drv, y_drv, ext_ref, stay, conv_start;
  logic [11:0] conv_res;
  logic [2:0] ch;
  logic [1:0] pwr;
  logic [0:63] dv;
  int n_errors = 0;
  int check_count = 0;
  int n_starts = 0;
  int s0;
  // Command, result word, expected {x, y, ext_ref}
  tsc_row_t rows [0:6] = '{'{8'h97, 12'ha5c, 3'b011}, '{8'hd0, 12'h3c6, 3'b100},
    '{8'hab, 12'hf0f, 3'b001}, '{8'hed, 12'h96a, 3'b001}, '{8'h82, 12'h001, 3'b000},
    '{8'hf7, 12'h800, 3'b001}, '{8'hb8, 12'h5a5, 3'b000}};
  // Pull-up on the interrupt wire
  assign irq_wire = irq_oe ? irq_n : 1'b1;
  tsc_serial_ctl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .serial_clock_i(sclk), .din_i(din), .conv_result_i(conv_res), .touch_detect_i(touch),
    .touch_irq_n_i(irq_wire), .dout_o(dout), .dout_oe_o(dout_oe), .busy_o(busy),
    .busy_oe_o(busy_oe), .touch_irq_n_o(irq_n), .touch_irq_oe_o(irq_oe),
    .channel_sel_o(ch), .resolution_sel_o(res_sel), .reference_sel_o(ref_sel),
    .power_ctl_o(pwr), .x_drive_o(x_drv), .y_drive_o(y_drv), .ext_ref_o(ext_ref),
    .stay_powered_o(stay), .conv_start_o(conv_start));
  tsc_host_model host (.clk_i(clk_i), .dout_i(dout), .dout_oe_i(dout_oe), .busy_i(busy),
    .busy_oe_i(busy_oe), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Conversion start pulses
  always @(posedge clk_i) begin
    if (conv_start === 1'b1) n_starts <= n_starts + 1;
  end
  task automatic chk(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Busy one clock after command end e, then result MSB first, then zero
  task automatic chk_conv(input int e, input logic [11:0] r, input logic r8);
    int nb;
    nb = r8 ? 8 : 12;
    chk(host.cap_b[e] === 1'b0 && host.cap_b[e+1] === 1'b1, "busy missing");
    chk(host.cap_b[e+2] === 1'b0, "busy too long");
    for (int i = 0; i < nb; i++) chk(host.cap_d[e+2+i] === r[11-i], "result bit");
    chk(host.cap_d[e+2+nb] === 1'b0, "result too long");
  endtask
  task automatic chk_cfg(input logic [7:0] c, input logic [2:0] xye);
    chk(ch === c[6:4] && res_sel === c[3], "channel or resolution");
    chk(ref_sel === c[2] && pwr === c[1:0], "reference or power");
    chk({x_drv, y_drv, ext_ref} === xye, "drivers or reference");
    chk(stay === (c[1:0] == 2'h3), "power hold");
  endtask
  task automatic chk_rst();
    chk(dout_oe === 1'b0 && busy_oe === 1'b0 && conv_start === 1'b0, "reset outputs");
    chk(pwr === 2'h0 && ch === 3'h0 && x_drv === 1'b0 && y_drv === 1'b0, "reset fields");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the expected run length
  initial begin
    repeat (25000) @(posedge clk_i);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    touch = 1'b0;
    conv_res = 12'h000;
    repeat (16) @(negedge clk_i);
    chk_rst();
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    for (int j = 0; j < 7; j++) begin
      conv_res = rows[j].res;
      s0 = n_starts;
      host.run({rows[j].cmd, 56'h0}, 24);
      chk(n_starts == s0 + 1, "start count");
      chk_cfg(rows[j].cmd, rows[j].xye);
      chk_conv(8, rows[j].res, rows[j].cmd[3]);
      chk(host.bad === 1'b0 && dout_oe === 1'b0 && busy_oe === 1'b0, "enables");
      touch = 1'b1;
      repeat (3) @(negedge clk_i);
      chk(irq_wire === (rows[j].cmd[1:0] != 2'h0), "touch interrupt");
      touch = 1'b0;
      repeat (3) @(negedge clk_i);
    end
    // Leading zeros, then overlapped 15 and 16 clock framing
    for (int g = 15; g <= 16; g++) begin
      dv = '0;
      dv[2 +: 8] = 8'h97;
      dv[g+2 +: 8] = 8'hab;
      conv_res = 12'hc35;
      fork
        host.run(dv, g + 24);
        begin
          @(posedge busy);
          @(negedge clk_i);
          conv_res = 12'h6e1;
        end
      join
      chk_conv(10, 12'hc35, 1'b0);
      chk_conv(g + 10, 12'h6e1, 1'b1);
      chk_cfg(8'hab, 3'b001);
    end
    // Partial command, then clocks while deselected
    s0 = n_starts;
    host.run({8'hd5, 56'h0}, 5);
    host.idle_clk(20);
    chk(n_starts == s0 && ch === 3'h2, "deselected bits taken");
    chk(host.bad === 1'b0 && dout_oe === 1'b0 && busy_oe === 1'b0, "deselect drive");
    host.run({8'hd3, 56'h0}, 24);
    chk_cfg(8'hd3, 3'b100);
    // Reset in mid-run re-arms the interrupt
    touch = 1'b1;
    repeat (2) @(negedge clk_i);
    chk(irq_wire === 1'b1, "interrupt while powered");
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_rst();
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk(irq_wire === 1'b0, "interrupt not armed");
    wrap_up();
  end
endmodule
